// *** hdl/probe_detect.sv ***
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Clock pin owned by unit after reset
// - Reset release with clock low holds cpu
// - Clock pin pulled up at startup
// - Hold flag set while cpu held
// - Writing one releases cpu, clears flag
// - Writing zero to hold flag ignored
// - Protected release refused, fault flag set
// - Reset hold counts as cold attach
// - Hot detector reset during any reset
// - Clock falling edge means hot attach
// - Pin reassigned disables hot until reset
// - Hot availability flag readable
// - Attached flag set on either detection
// - Protection suppresses hot detection
// - No detection before power reset ends
// - Write guard covers all but mailboxes
// - Debugger accesses bypass write guard
// - Runs in sleep while clock runs
module probe_detect (
  input  wire logic        CLK,           // System clock, 40 MHz
  input  wire logic        NRST,          // Power-on reset, active low
  input  wire logic        EXT_RST_N,     // External reset pin, active low
  input  wire logic        SWCLK_IN,      // Serial-wire clock pin level
  input  wire logic        FLASH_SECURE,  // Flash security bit, device protected
  input  wire logic        AXI_DEBUG,     // Access comes from debugger port
  output logic             SWCLK_PULLUP,  // Internal pull-up enable on clock pin
  output logic             SWCLK_OWNED,   // Clock pin assigned to this unit
  output logic             CPU_RST_HOLD,  // Hold cpu core in reset
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);
  import probe_detect_pkg::*;

  // ****************************************
  // Reset synchronisers
  // ****************************************
  logic       por_s1_r;      // Power reset release, stage one
  logic       por_n_r;       // Synchronised power reset, active low
  logic       ext_s1_r;      // External reset pin, stage one
  logic       ext_s2_r;      // External reset pin, stage two
  logic       ext_q_r;       // Previous external reset level
  logic       clk_s1_r;      // Clock pin, stage one
  logic       clk_s2_r;      // Clock pin, stage two
  logic       clk_q_r;       // Previous clock pin level
  logic       dbg_s1_r;      // Debugger-port flag, stage one
  logic       dbg_s2_r;      // Debugger-port flag, stage two

  // Power reset released through two flops
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      por_s1_r <= 1'b0;
      por_n_r  <= 1'b0;
    end else begin
      por_s1_r <= 1'b1;
      por_n_r  <= por_s1_r;
    end
  end

  // Pin inputs pass two flops before use
  always_ff @(posedge CLK or negedge por_n_r) begin
    if (!por_n_r) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_q_r  <= 1'b0;
      clk_s1_r <= 1'b1;
      clk_s2_r <= 1'b1;
      clk_q_r  <= 1'b1;
      dbg_s1_r <= 1'b0;
      dbg_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= EXT_RST_N;
      ext_s2_r <= ext_s1_r;
      ext_q_r  <= ext_s2_r;
      clk_s1_r <= SWCLK_IN;
      clk_s2_r <= clk_s1_r;
      clk_q_r  <= clk_s2_r;
      dbg_s1_r <= AXI_DEBUG;
      dbg_s2_r <= dbg_s1_r;
    end
  end

  // ****************************************
  // Detection events
  // ****************************************
  logic       hold_r;        // Cpu reset hold flag
  logic       fault_r;       // Protection fault flag
  logic       attached_r;    // Probe attached flag
  logic       hot_avail_r;   // Hot attach still possible
  logic [2:0] control_r;     // Guard, mux off, alt function
  logic [31:0] mbox0_r;      // Mailbox zero
  logic [31:0] mbox1_r;      // Mailbox one

  // Reset release edge and clock falling edge, only after power reset ends
  wire ext_release = ext_s2_r & ~ext_q_r;
  wire cold_hit    = ext_release & ~clk_s2_r;
  wire in_reset    = ~ext_s2_r;
  wire hot_hit     = ~in_reset & hot_avail_r & ~FLASH_SECURE
                     & clk_q_r & ~clk_s2_r;
  wire pin_lost    = control_r[MUX_OFF_BIT] | control_r[ALT_FUNC_BIT];

  // ****************************************
  // Write channel
  // ****************************************
  logic        aw_have_r;    // Address captured
  logic        w_have_r;     // Data captured
  logic [7:0]  awaddr_r;     // Captured write address
  logic [31:0] wdata_r;      // Captured write data
  logic [3:0]  wstrb_r;      // Captured byte enables

  wire aw_take  = AWVALID & AWREADY;
  wire w_take   = WVALID & WREADY;
  wire wr_go    = aw_have_r & w_have_r & ~BVALID;
  wire wr_guard = control_r[GUARD_BIT] & ~dbg_s2_r;
  wire sel_st1  = awaddr_r == STATUS_FIRST_OFS;
  wire sel_st2  = awaddr_r == STATUS_SECOND_OFS;
  wire sel_mb0  = awaddr_r == MAILBOX_ZERO_OFS;
  wire sel_mb1  = awaddr_r == MAILBOX_ONE_OFS;
  wire sel_ctl  = awaddr_r == CONTROL_OFS;
  wire wr_known = sel_st1 | sel_st2 | sel_mb0 | sel_mb1 | sel_ctl;
  // Guard covers every mapped register except the two mailboxes
  wire wr_block = wr_guard & wr_known & ~(sel_mb0 | sel_mb1);
  wire wr_ok    = wr_go & ~wr_block;
  wire rel_req  = wr_ok & sel_st1 & wstrb_r[0] & wdata_r[HOLD_BIT];
  wire rel_do   = rel_req & ~FLASH_SECURE;
  wire rel_deny = rel_req & FLASH_SECURE;

  // Merge byte lanes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Capture address and data in either order, answer once both held
  always_ff @(posedge CLK or negedge por_n_r) begin
    if (!por_n_r) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= RESP_OKAY;
    end else begin
      AWREADY <= ~aw_have_r & ~aw_take & ~AWREADY;
      WREADY  <= ~w_have_r & ~w_take & ~WREADY;
      if (aw_take) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= AWADDR;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
      end
      if (wr_go) begin
        // Response follows both halves
        BVALID    <= 1'b1;
        BRESP     <= !wr_known ? RESP_DECERR : (wr_block ? RESP_SLVERR : RESP_OKAY);
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status and control state
  // ****************************************
  // Flags and control, power reset and external reset restart detection
  always_ff @(posedge CLK or negedge por_n_r) begin
    if (!por_n_r) begin
      hold_r      <= 1'b0;
      fault_r     <= 1'b0;
      attached_r  <= 1'b0;
      hot_avail_r <= 1'b1;
      control_r   <= CONTROL_RESET;
      mbox0_r     <= MAILBOX_RESET;
      mbox1_r     <= MAILBOX_RESET;
    end else begin
      // Hold flag: cold hit sets, allowed release clears; set wins
      if (cold_hit) begin
        hold_r <= 1'b1;
      end else if (rel_do) begin
        hold_r <= 1'b0;
      end
      // Fault flag sticky; write one clears, new denial wins
      if (rel_deny) begin
        fault_r <= 1'b1;
      end else if (wr_ok && sel_st1 && wstrb_r[0] && wdata_r[FAULT_BIT]) begin
        fault_r <= 1'b0;
      end
      // Either detection marks a probe present
      if (cold_hit || hot_hit) begin
        attached_r <= 1'b1;
      end else if (wr_ok && sel_st2 && wstrb_r[0] && wdata_r[ATTACHED_BIT]) begin
        attached_r <= 1'b0;
      end
      // Hot detection lost on pin reassignment, back only on reset
      if (in_reset) begin
        hot_avail_r <= 1'b1;
        control_r   <= CONTROL_RESET;
      end else begin
        if (pin_lost) begin
          hot_avail_r <= 1'b0;
        end
        if (wr_ok && sel_ctl && wstrb_r[0]) begin
          control_r <= wdata_r[2:0];
        end
      end
      // Mailboxes ignore the write guard
      if (wr_go && sel_mb0) begin
        mbox0_r <= merge(mbox0_r, wdata_r, wstrb_r);
      end
      if (wr_go && sel_mb1) begin
        mbox1_r <= merge(mbox1_r, wdata_r, wstrb_r);
      end
    end
  end

  // ****************************************
  // Pin and cpu outputs
  // ****************************************
  // Pull-up and ownership from reset until pin reassigned; hold follows flag or reset
  always_ff @(posedge CLK or negedge por_n_r) begin
    if (!por_n_r) begin
      SWCLK_PULLUP <= 1'b1;
      SWCLK_OWNED  <= 1'b1;
      CPU_RST_HOLD <= 1'b1;
    end else begin
      SWCLK_PULLUP <= ~pin_lost;
      SWCLK_OWNED  <= ~pin_lost;
      CPU_RST_HOLD <= in_reset | (hold_r & ~rel_do) | cold_hit;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  wire [31:0] st1_word = {29'h0, fault_r, hold_r, 1'b0};
  wire [31:0] st2_word = {29'h0, hot_avail_r & ~FLASH_SECURE, attached_r, 1'b0};
  wire [31:0] ctl_word = {29'h0, control_r};
  wire        rd_known = (ARADDR == STATUS_FIRST_OFS) | (ARADDR == STATUS_SECOND_OFS)
                         | (ARADDR == MAILBOX_ZERO_OFS) | (ARADDR == MAILBOX_ONE_OFS)
                         | (ARADDR == CONTROL_OFS);
  wire [31:0] rd_word  = (ARADDR == STATUS_FIRST_OFS)  ? st1_word :
                         (ARADDR == STATUS_SECOND_OFS) ? st2_word :
                         (ARADDR == MAILBOX_ZERO_OFS)  ? mbox0_r  :
                         (ARADDR == MAILBOX_ONE_OFS)   ? mbox1_r  :
                         (ARADDR == CONTROL_OFS)       ? ctl_word : 32'h0000_0000;

  // Accept one read, answer next cycle, hold until taken
  always_ff @(posedge CLK or negedge por_n_r) begin
    if (!por_n_r) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= RESP_OKAY;
    end else begin
      ARREADY <= ~RVALID & ~ARREADY & ~ARVALID ? 1'b1 : (~RVALID & ~ARREADY & ARVALID);
      if (ARVALID && ARREADY) begin
        RVALID  <= 1'b1;
        RDATA   <= rd_word;
        RRESP   <= rd_known ? RESP_OKAY : RESP_DECERR;
        ARREADY <= 1'b0;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

endmodule

// *** hdl/probe_detect_pkg.sv ***
package probe_detect_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0]  STATUS_FIRST_OFS  = 8'h00;   // Hold flag, fault flag
  localparam logic [7:0]  STATUS_SECOND_OFS = 8'h04;   // Attached, hot available
  localparam logic [7:0]  MAILBOX_ZERO_OFS  = 8'h08;   // Scratch word zero
  localparam logic [7:0]  MAILBOX_ONE_OFS   = 8'h0C;   // Scratch word one
  localparam logic [7:0]  CONTROL_OFS       = 8'h10;   // Write guard, mux control

  // ****************************************
  // Field positions
  // ****************************************
  localparam int HOLD_BIT      = 1;   // First status: cpu hold flag
  localparam int FAULT_BIT     = 2;   // First status: protection fault
  localparam int ATTACHED_BIT  = 1;   // Second status: probe attached
  localparam int HOT_AVAIL_BIT = 2;   // Second status: hot attach available
  localparam int GUARD_BIT     = 0;   // Control: write guard enable
  localparam int MUX_OFF_BIT   = 1;   // Control: pin mux disabled
  localparam int ALT_FUNC_BIT  = 2;   // Control: clock pin given other function

  // ****************************************
  // Reset values and bus answers
  // ****************************************
  localparam logic [31:0] MAILBOX_RESET = 32'h0000_0000;
  localparam logic [2:0]  CONTROL_RESET = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

endpackage

// *** dv/probe_detect_chk.sv ***
`timescale 1ns/1ps
// ****
// Port checker
// ****
module probe_detect_chk
  import probe_detect_pkg::*;
(
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        EXT_RST_N,
  input wire logic        SWCLK_IN,
  input wire logic        FLASH_SECURE,
  input wire logic        SWCLK_PULLUP,
  input wire logic        SWCLK_OWNED,
  input wire logic        CPU_RST_HOLD,
  input wire logic [7:0]  AWADDR,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID
);
  logic [7:0] wa_r;  // Last taken write address
  logic       wd_r;  // Last hold bit written
  // Remember taken write halves
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wa_r <= 8'h00;
      wd_r <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) wa_r <= AWADDR;
      if (WVALID && WREADY) wd_r <= WDATA[HOLD_BIT];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  chk_reset_values: assert property (
    $rose(NRST) |-> SWCLK_OWNED && SWCLK_PULLUP && CPU_RST_HOLD) else $error("bad reset outputs");
  chk_cold_hold: assert property (
    $rose(EXT_RST_N) && !SWCLK_IN |-> CPU_RST_HOLD [*8]) else $error("cold hold lost");
  chk_warm_run: assert property (
    $rose(EXT_RST_N) && SWCLK_IN |-> ##[1:12] !CPU_RST_HOLD) else $error("cpu not let run");
  chk_release_one: assert property (
    $rose(BVALID) && BRESP == RESP_OKAY && wa_r == STATUS_FIRST_OFS && wd_r && EXT_RST_N && !FLASH_SECURE
    |-> ##[0:3] !CPU_RST_HOLD) else $error("hold not released");
  chk_write_zero: assert property (
    $rose(BVALID) && wa_r == STATUS_FIRST_OFS && !wd_r && $past(CPU_RST_HOLD, 2) && EXT_RST_N
    |-> CPU_RST_HOLD [*4]) else $error("zero write released cpu");
  chk_secure_keep: assert property (
    $rose(BVALID) && wa_r == STATUS_FIRST_OFS && wd_r && FLASH_SECURE && $past(CPU_RST_HOLD, 2)
    |-> CPU_RST_HOLD [*4]) else $error("protected release taken");
  chk_pullup_drop: assert property (
    $fell(SWCLK_PULLUP) |-> wa_r == CONTROL_OFS) else $error("pull-up dropped unasked");
  chk_owned_drop: assert property (
    $fell(SWCLK_OWNED) |-> wa_r == CONTROL_OFS) else $error("pin lost unasked");
  chk_mailbox_open: assert property (
    $rose(BVALID) && wa_r == MAILBOX_ZERO_OFS |-> BRESP == RESP_OKAY) else $error("mailbox refused");
endmodule
bind probe_detect probe_detect_chk u_chk (
  .CLK, .NRST, .EXT_RST_N, .SWCLK_IN, .FLASH_SECURE, .SWCLK_PULLUP, .SWCLK_OWNED, .CPU_RST_HOLD,
  .AWADDR, .AWVALID, .AWREADY, .WDATA, .WVALID, .WREADY, .BRESP, .BVALID);

// *** dv/debug_adapter_model.sv ***
`timescale 1ns/1ps
// ****
// Debug adapter model
// ****
module debug_adapter_model (
  output logic ext_rst_n,  // External reset drive
  output logic swclk       // Link clock, idles at pull-up level
);
  // Reset held from power-up past the power reset
  initial begin
    ext_rst_n = 1'b0;
    swclk = 1'b1;
  end
  // Reset pulse; a low clock at release asks for a hold
  task automatic ext_pulse(input logic lvl);
    #3 ext_rst_n = 1'b0;
    #1010 swclk = 1'b0;
    #1010 swclk = lvl;
    #1010 ext_rst_n = 1'b1;
    #2010 swclk = 1'b1;
  endtask
  // Frame of n link clocks, ends high
  task automatic burst(input int n);
    #7;
    repeat (n) begin
      #100 swclk = 1'b0;
      #100 swclk = 1'b1;
    end
  endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// ****
// Bench top
// ****
module testbench;
  import probe_detect_pkg::*;
  localparam logic [31:0] HOLD  = 32'h1 << HOLD_BIT;       // Hold flag
  localparam logic [31:0] FAULT = 32'h1 << FAULT_BIT;      // Fault flag
  localparam logic [31:0] SEEN  = 32'h1 << ATTACHED_BIT;   // Attached flag
  localparam logic [31:0] HOT   = 32'h1 << HOT_AVAIL_BIT;  // Hot available
  logic        CLK = 1'b0;
  logic        NRST, FLASH_SECURE, AXI_DEBUG, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        SWCLK_PULLUP, SWCLK_OWNED, CPU_RST_HOLD, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic        EXT_RST_N, SWCLK_IN;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] sel [2] = '{32'h1 << ALT_FUNC_BIT, 32'h1 << MUX_OFF_BIT};  // Pin reassign codes
  int          miscompares = 0;
  int          n_compared = 0;
  always #12.5 CLK = ~CLK;
  debug_adapter_model adapter (.ext_rst_n(EXT_RST_N), .swclk(SWCLK_IN));
  probe_detect DUT (
    .CLK, .NRST, .EXT_RST_N, .SWCLK_IN, .FLASH_SECURE, .AXI_DEBUG, .SWCLK_PULLUP, .SWCLK_OWNED,
    .CPU_RST_HOLD, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
  // Count and report one comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Pull-up, ownership, cpu hold
  task automatic pins(input logic [2:0] e);
    @(posedge CLK);
    cmp({29'h0, SWCLK_PULLUP, SWCLK_OWNED, CPU_RST_HOLD}, {29'h0, e});
  endtask
  // Bus write, both halves offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    cmp({30'h0, BRESP}, {30'h0, r});
  endtask
  // Bus read with expected word and answer
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    cmp(RDATA, d);
    cmp({30'h0, RRESP}, {30'h0, r});
  endtask
  // Verdict and end of run
  task automatic test_done;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {NRST, FLASH_SECURE, AXI_DEBUG, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 8'h00;
    {AWADDR, ARADDR, WDATA} = 48'h0000_0000_0000;
    WSTRB = 4'hF;
    repeat (16) @(posedge CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CLK);
    pins(3'b111);
    rd(STATUS_SECOND_OFS, HOT);
    adapter.ext_pulse(1'b0);
    rd(STATUS_FIRST_OFS, HOLD);
    rd(STATUS_SECOND_OFS, SEEN | HOT);
    pins(3'b111);
    wr(STATUS_FIRST_OFS, 32'h0);
    rd(STATUS_FIRST_OFS, HOLD);
    FLASH_SECURE <= 1'b1;
    wr(STATUS_FIRST_OFS, HOLD);
    rd(STATUS_FIRST_OFS, HOLD | FAULT);
    wr(STATUS_FIRST_OFS, FAULT);
    FLASH_SECURE <= 1'b0;
    wr(STATUS_FIRST_OFS, HOLD);
    rd(STATUS_FIRST_OFS, 32'h0);
    pins(3'b110);
    wr(STATUS_SECOND_OFS, SEEN);
    FLASH_SECURE <= 1'b1;
    adapter.burst(2);
    rd(STATUS_SECOND_OFS, 32'h0);
    FLASH_SECURE <= 1'b0;
    rd(STATUS_SECOND_OFS, HOT);
    adapter.burst(2);
    rd(STATUS_SECOND_OFS, SEEN | HOT);
    wr(CONTROL_OFS, 32'h1 << GUARD_BIT);
    wr(MAILBOX_ZERO_OFS, 32'hA5A5_5A5A);
    rd(MAILBOX_ZERO_OFS, 32'hA5A5_5A5A);
    wr(STATUS_SECOND_OFS, SEEN, RESP_SLVERR);
    wr(STATUS_FIRST_OFS, FAULT, RESP_SLVERR);
    AXI_DEBUG <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(STATUS_SECOND_OFS, SEEN);
    wr(CONTROL_OFS, 32'h0);
    rd(CONTROL_OFS, 32'h0);
    AXI_DEBUG <= 1'b0;
    rd(8'h20, 32'h0, RESP_DECERR);
    foreach (sel[i]) begin
      adapter.ext_pulse(1'b1);
      pins(3'b110);
      rd(STATUS_SECOND_OFS, HOT);
      wr(CONTROL_OFS, sel[i]);
      rd(STATUS_SECOND_OFS, 32'h0);
      adapter.burst(2);
      rd(STATUS_SECOND_OFS, 32'h0);
    end
    test_done();
  end
endmodule
